// file: cpu_regs.v
// processor register file: banked data, address and frame registers,
// bases, program counter, stack pointers and flags, with an operand
// port for the execution logic and an axi4-lite slave for software
// assumes all inputs synchronous to CLK; one axi write, one read at once
`timescale 1ns/100ps
`default_nettype none
`include "cpu_regs_defines.vh"

module cpu_regs (
   // clock and reset
   input  wire        CLK,
   input  wire        ARST_N,
   // axi4-lite write
   input  wire [7:0]  AWADDR,
   input  wire        AWVALID,
   output reg         AWREADY,
   input  wire [31:0] WDATA,
   input  wire [3:0]  WSTRB,
   input  wire        WVALID,
   output reg         WREADY,
   output reg  [1:0]  BRESP,
   output reg         BVALID,
   input  wire        BREADY,
   // axi4-lite read
   input  wire [7:0]  ARADDR,
   input  wire        ARVALID,
   output reg         ARREADY,
   output reg  [31:0] RDATA,
   output reg  [1:0]  RRESP,
   output reg         RVALID,
   input  wire        RREADY,
   // operand read
   input  wire [3:0]  RD_SEL,
   input  wire [1:0]  RD_SIZE,
   output reg  [31:0] RD_DATA,
   // operand write
   input  wire        WR_EN,
   input  wire [3:0]  WR_SEL,
   input  wire [1:0]  WR_SIZE,
   input  wire [31:0] WR_DATA,
   // alu flags
   input  wire        ALU_EN,
   input  wire        ALU_C,
   input  wire        ALU_Z,
   input  wire        ALU_S,
   input  wire        ALU_O,
   // sequencing
   input  wire        INSN_DONE,
   input  wire        PC_LOAD,
   input  wire [19:0] PC_VALUE,
   // interrupts
   input  wire        IRQ_REQ,
   input  wire [2:0]  IRQ_PRIO,
   input  wire        IRQ_ACK,
   input  wire        SSTEP_ACK,
   input  wire        SWI_EXEC,
   input  wire [5:0]  SWI_NUM,
   output reg         IRQ_TAKE,
   output reg         SSTEP_REQ,
   // addressing bases
   output reg  [15:0] ADDR_PTR0,
   output reg  [15:0] ADDR_PTR1,
   output reg  [15:0] FRAME_BASE,
   output wire [15:0] STATIC_BASE,
   output reg  [15:0] ACTIVE_SP,
   output wire [19:0] PROG_COUNTER,
   output wire [19:0] VEC_BASE,
   output wire [15:0] FLAGS,
   output wire        BANK
);

   // *****
   // shared helpers
   // *****
   function [15:0] word_of;
      input [111:0] flat;
      input [2:0]   idx;
      begin
         word_of = flat[{idx, 4'h0} +: 16];
      end
   endfunction

   // pair partner: {pairable, upper word index}
   function [3:0] pair_of;
      input [3:0] sel;
      begin
         case (sel)
            `SEL_D0: pair_of = {1'b1, `PHI_D0};
            `SEL_D1: pair_of = {1'b1, `PHI_D1};
            `SEL_A0: pair_of = {1'b1, `PHI_A0};
            default: pair_of = 4'h0;
         endcase
      end
   endfunction

   function [31:0] view;
      input [1:0]  size;
      input [15:0] lo;
      input [15:0] hi;
      input        ok;
      begin
         case (size)
            `SZ_BLO:  view = {24'h000000, lo[7:0]};
            `SZ_BHI:  view = {24'h000000, lo[15:8]};
            `SZ_PAIR: view = ok ? {hi, lo} : {16'h0000, lo};
            default:  view = {16'h0000, lo};
         endcase
      end
   endfunction

   function [15:0] merge;
      input [1:0]  size;
      input [15:0] old;
      input [15:0] nw;
      begin
         case (size)
            `SZ_BLO: merge = {old[15:8], nw[7:0]};
            `SZ_BHI: merge = {nw[7:0], old[7:0]};
            default: merge = nw;
         endcase
      end
   endfunction

   function [15:0] strb16;
      input [15:0] old;
      input [31:0] wd;
      input [3:0]  st;
      begin
         strb16 = {st[1] ? wd[15:8] : old[15:8],
                   st[0] ? wd[7:0] : old[7:0]};
      end
   endfunction

   function [19:0] strb20;
      input [19:0] old;
      input [31:0] wd;
      input [3:0]  st;
      begin
         strb20 = {st[2] ? wd[19:16] : old[19:16],
                   strb16(old[15:0], wd, st)};
      end
   endfunction

   // *****
   // state
   // *****
   wire [111:0] flat0;
   wire [111:0] flat1;
   wire [15:0]  flags_r;
   wire [15:0]  flags_nxt;
   reg          bank_r;
   reg  [15:0]  sb_r;
   reg  [15:0]  usp_r;
   reg  [15:0]  isp_r;
   reg  [19:0]  vector_table_base_r;
   reg  [19:0]  pc_r;
   reg          aw_full_r;
   reg          w_full_r;
   reg  [5:0]   aw_idx_r;
   reg  [31:0]  wdata_r;
   reg  [3:0]   wstrb_r;

   wire [111:0] act_flat = bank_r ? flat1 : flat0;
   wire         u_flag = flags_r[`FLG_U];

   assign STATIC_BASE  = sb_r;
   assign PROG_COUNTER = pc_r;
   assign VEC_BASE     = vector_table_base_r;
   assign FLAGS        = flags_r;
   assign BANK         = bank_r;

   // *****
   // operand read, one cycle latency
   // *****
   reg  [15:0] e_lo;
   reg  [15:0] e_hi;
   reg  [19:0] e_w20;
   reg         e_wide;
   wire [3:0]  rd_pair = pair_of(RD_SEL);

   always @* begin
      e_lo   = 16'h0000;
      e_hi   = word_of(act_flat, rd_pair[2:0]);
      e_w20  = `W20_RST;
      e_wide = 1'b0;
      case (RD_SEL)
         `SEL_SB:   e_lo = sb_r;
         `SEL_USP:  e_lo = usp_r;
         `SEL_ISP:  e_lo = isp_r;
         `SEL_SP:   e_lo = u_flag ? usp_r : isp_r;
         `SEL_FLG:  e_lo = flags_r;
         `SEL_VECTOR_TABLE_BASE: begin
            e_w20  = vector_table_base_r;
            e_wide = 1'b1;
         end
         `SEL_PC: begin
            e_w20  = pc_r;
            e_wide = 1'b1;
         end
         default: begin
            if (RD_SEL <= `SEL_FB)
               e_lo = word_of(act_flat, RD_SEL[2:0]);
         end
      endcase
   end

   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N)
         RD_DATA <= 32'h00000000;
      else if (e_wide)
         RD_DATA <= {12'h000, e_w20};
      else
         RD_DATA <= view(RD_SIZE, e_lo, e_hi, rd_pair[3]);
   end

   // *****
   // write arbitration: operand port first
   // *****
   wire [3:0]  wr_pair  = pair_of(WR_SEL);
   wire        wr_bnk   = WR_EN & (WR_SEL <= `SEL_FB);
   wire        ax_go    = aw_full_r & w_full_r & ~BVALID & ~WR_EN;
   wire        ax_ok    = aw_idx_r <= `IDX_PC;
   wire        ax_bsel  = aw_idx_r >= `IDX_BANK1;
   wire [5:0]  ax_sub   = aw_idx_r - `IDX_BANK1;
   wire [2:0]  ax_ridx  = ax_bsel ? ax_sub[2:0] : aw_idx_r[2:0];
   wire        ax_bnk   = ax_go & (aw_idx_r < `IDX_SB);
   wire [15:0] wr_old   = word_of(act_flat, WR_SEL[2:0]);
   wire [15:0] ax_old   = word_of(ax_bsel ? flat1 : flat0, ax_ridx);

   wire        rb_bank  = WR_EN ? bank_r : ax_bsel;
   wire        rb_we_a  = wr_bnk | ax_bnk;
   wire [2:0]  rb_ia    = WR_EN ? WR_SEL[2:0] : ax_ridx;
   wire [15:0] rb_da    = WR_EN ? merge(WR_SIZE, wr_old, WR_DATA[15:0])
                                : strb16(ax_old, wdata_r, wstrb_r);
   wire        rb_we_b  = wr_bnk & wr_pair[3] & (WR_SIZE == `SZ_PAIR);

   wire        fl_we    = (WR_EN & (WR_SEL == `SEL_FLG)) |
                          (ax_go & (aw_idx_r == `IDX_FLG));
   wire [15:0] fl_wd    = WR_EN ? merge(WR_SIZE, flags_r, WR_DATA[15:0])
                                : strb16(flags_r, wdata_r, wstrb_r);

   reg_bank u_bank (
      .clk    (CLK),
      .arst_n (ARST_N),
      .wbank  (rb_bank),
      .we_a   (rb_we_a),
      .ia     (rb_ia),
      .da     (rb_da),
      .we_b   (rb_we_b),
      .ib     (wr_pair[2:0]),
      .db     (WR_DATA[31:16]),
      .flat0  (flat0),
      .flat1  (flat1)
   );

   flag_unit u_flags (
      .clk       (CLK),
      .arst_n    (ARST_N),
      .we        (fl_we),
      .wd        (fl_wd),
      .alu_en    (ALU_EN),
      .alu_c     (ALU_C),
      .alu_z     (ALU_Z),
      .alu_s     (ALU_S),
      .alu_o     (ALU_O),
      .hw_ack    (IRQ_ACK),
      .step_ack  (SSTEP_ACK),
      .swi_exec  (SWI_EXEC),
      .swi_num   (SWI_NUM),
      .flags_r   (flags_r),
      .flags_nxt (flags_nxt)
   );

   // *****
   // single registers
   // *****
   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         sb_r   <= `REG_RST;
         usp_r  <= `REG_RST;
         isp_r  <= `REG_RST;
         vector_table_base_r <= `W20_RST;
         pc_r   <= `W20_RST;
      end else begin
         if (WR_EN) begin
            case (WR_SEL)
               `SEL_SB:   sb_r  <= merge(WR_SIZE, sb_r, WR_DATA[15:0]);
               `SEL_USP:  usp_r <= merge(WR_SIZE, usp_r, WR_DATA[15:0]);
               `SEL_ISP:  isp_r <= merge(WR_SIZE, isp_r, WR_DATA[15:0]);
               `SEL_SP: begin
                  if (u_flag)
                     usp_r <= merge(WR_SIZE, usp_r, WR_DATA[15:0]);
                  else
                     isp_r <= merge(WR_SIZE, isp_r, WR_DATA[15:0]);
               end
               `SEL_VECTOR_TABLE_BASE: vector_table_base_r <= WR_DATA[19:0];
               default: ;
            endcase
         end else if (ax_go) begin
            case (aw_idx_r)
               `IDX_SB:   sb_r   <= strb16(sb_r, wdata_r, wstrb_r);
               `IDX_USP:  usp_r  <= strb16(usp_r, wdata_r, wstrb_r);
               `IDX_ISP:  isp_r  <= strb16(isp_r, wdata_r, wstrb_r);
               `IDX_VECTOR_TABLE_BASE: vector_table_base_r <= strb20(vector_table_base_r, wdata_r, wstrb_r);
               default: ;
            endcase
         end
         if (PC_LOAD)
            pc_r <= PC_VALUE;
         else if (WR_EN & (WR_SEL == `SEL_PC))
            pc_r <= WR_DATA[19:0];
         else if (ax_go & (aw_idx_r == `IDX_PC))
            pc_r <= strb20(pc_r, wdata_r, wstrb_r);
      end
   end

   // *****
   // bank, interrupt gating and base outputs
   // *****
   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         bank_r     <= 1'b0;
         IRQ_TAKE   <= 1'b0;
         SSTEP_REQ  <= 1'b0;
         ADDR_PTR0  <= `REG_RST;
         ADDR_PTR1  <= `REG_RST;
         FRAME_BASE <= `REG_RST;
         ACTIVE_SP  <= `REG_RST;
      end else begin
         if (INSN_DONE)
            bank_r <= flags_nxt[`FLG_B];
         IRQ_TAKE <= IRQ_REQ & flags_r[`FLG_I] &
                     (IRQ_PRIO > flags_r[`FLG_IPL_HI:`FLG_IPL_LO]);
         if (INSN_DONE & flags_r[`FLG_D])
            SSTEP_REQ <= 1'b1;
         else if (SSTEP_ACK)
            SSTEP_REQ <= 1'b0;
         ADDR_PTR0  <= word_of(act_flat, `IDX_A0);
         ADDR_PTR1  <= word_of(act_flat, `IDX_A1);
         FRAME_BASE <= word_of(act_flat, `IDX_FB);
         ACTIVE_SP  <= u_flag ? usp_r : isp_r;
      end
   end

   // *****
   // axi4-lite write channel
   // *****
   wire aw_take = AWVALID & AWREADY;
   wire w_take  = WVALID & WREADY;

   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         AWREADY   <= 1'b0;
         WREADY    <= 1'b0;
         BVALID    <= 1'b0;
         BRESP     <= `RESP_OKAY;
         aw_full_r <= 1'b0;
         w_full_r  <= 1'b0;
         aw_idx_r  <= 6'h00;
         wdata_r   <= 32'h00000000;
         wstrb_r   <= 4'h0;
      end else begin
         AWREADY <= ax_go | (~aw_full_r & ~aw_take);
         WREADY  <= ax_go | (~w_full_r & ~w_take);
         if (aw_take) begin
            aw_full_r <= 1'b1;
            aw_idx_r  <= AWADDR[7:2];
         end
         if (w_take) begin
            w_full_r <= 1'b1;
            wdata_r  <= WDATA;
            wstrb_r  <= WSTRB;
         end
         if (ax_go) begin
            aw_full_r <= 1'b0;
            w_full_r  <= 1'b0;
            BVALID    <= 1'b1;
            BRESP     <= ax_ok ? `RESP_OKAY : `RESP_SLV;
         end else if (BREADY)
            BVALID <= 1'b0;
      end
   end

   // *****
   // axi4-lite read channel
   // *****
   wire       ar_take = ARVALID & ARREADY;
   wire [5:0] ar_idx  = ARADDR[7:2];
   wire [5:0] ar_sub  = ar_idx - `IDX_BANK1;
   reg [19:0] ax_rd;
   reg        ax_rok;

   always @* begin
      ax_rd  = `W20_RST;
      ax_rok = 1'b1;
      case (ar_idx)
         `IDX_SB:   ax_rd = {4'h0, sb_r};
         `IDX_USP:  ax_rd = {4'h0, usp_r};
         `IDX_ISP:  ax_rd = {4'h0, isp_r};
         `IDX_FLG:  ax_rd = {4'h0, flags_r};
         `IDX_VECTOR_TABLE_BASE: ax_rd = vector_table_base_r;
         `IDX_PC:   ax_rd = pc_r;
         default: begin
            if (ar_idx < `IDX_BANK1)
               ax_rd = {4'h0, word_of(flat0, ar_idx[2:0])};
            else if (ar_idx < `IDX_SB)
               ax_rd = {4'h0, word_of(flat1, ar_sub[2:0])};
            else
               ax_rok = 1'b0;
         end
      endcase
   end

   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ARREADY <= 1'b0;
         RVALID  <= 1'b0;
         RDATA   <= 32'h00000000;
         RRESP   <= `RESP_OKAY;
      end else begin
         ARREADY <= (~RVALID & ~ar_take) | (RVALID & RREADY);
         if (ar_take) begin
            RVALID <= 1'b1;
            RDATA  <= {12'h000, ax_rd};
            RRESP  <= ax_rok ? `RESP_OKAY : `RESP_SLV;
         end else if (RREADY)
            RVALID <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// file: cpu_regs_defines.vh
// register select codes, view sizes, flag bit positions and bus map
// of the processor register file; included by every design file
`ifndef CPU_REGS_DEFINES_VH
`define CPU_REGS_DEFINES_VH

// *****
// operand port register selects
// *****
`define SEL_D0    4'h0
`define SEL_D1    4'h1
`define SEL_D2    4'h2
`define SEL_D3    4'h3
`define SEL_A0    4'h4
`define SEL_A1    4'h5
`define SEL_FB    4'h6
`define SEL_SB    4'h7
`define SEL_USP   4'h8
`define SEL_ISP   4'h9
`define SEL_SP    4'ha
`define SEL_FLG   4'hb
`define SEL_VECTOR_TABLE_BASE  4'hc
`define SEL_PC    4'hd

// *****
// view sizes and pair partners
// *****
`define SZ_BLO    2'h0
`define SZ_BHI    2'h1
`define SZ_WORD   2'h2
`define SZ_PAIR   2'h3
`define PHI_D0    3'h2
`define PHI_D1    3'h3
`define PHI_A0    3'h5
`define IDX_FB    3'h6
`define IDX_A0    3'h4
`define IDX_A1    3'h5

// *****
// flag bit positions and masks
// *****
`define FLG_C     0
`define FLG_D     1
`define FLG_Z     2
`define FLG_S     3
`define FLG_B     4
`define FLG_O     5
`define FLG_I     6
`define FLG_U     7
`define FLG_IPL_LO 12
`define FLG_IPL_HI 14
`define FLG_WMASK 16'h70ff
`define SWI_U_LIM 6'h20

// *****
// reset values
// *****
`define REG_RST   16'h0000
`define FLG_RST   16'h0000
`define W20_RST   20'h00000

// *****
// bus word indices (byte address = index * 4)
// *****
`define IDX_BANK1 6'h07
`define IDX_SB    6'h0e
`define IDX_USP   6'h0f
`define IDX_ISP   6'h10
`define IDX_FLG   6'h11
`define IDX_VECTOR_TABLE_BASE  6'h12
`define IDX_PC    6'h13
`define RESP_OKAY 2'h0
`define RESP_SLV  2'h2

`endif

// file: reg_bank.v
// two banks of seven banked 16-bit registers with two write ports
// assumes the caller never writes one word through both ports at once
`timescale 1ns/100ps
`default_nettype none
`include "cpu_regs_defines.vh"

module reg_bank (
   // clock and reset
   input  wire         clk,
   input  wire         arst_n,
   // write ports, both into bank wbank
   input  wire         wbank,
   input  wire         we_a,
   input  wire [2:0]   ia,
   input  wire [15:0]  da,
   input  wire         we_b,
   input  wire [2:0]   ib,
   input  wire [15:0]  db,
   // contents of both banks, word i at bits 16i+15..16i
   output wire [111:0] flat0,
   output wire [111:0] flat1
);

   reg [15:0] b0 [0:6];
   reg [15:0] b1 [0:6];
   integer    i;
   genvar     g;

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (i = 0; i < 7; i = i + 1) begin
            b0[i] <= `REG_RST;
            b1[i] <= `REG_RST;
         end
      end else begin
         if (we_a & ~wbank) b0[ia] <= da;
         if (we_a & wbank) b1[ia] <= da;
         if (we_b & ~wbank) b0[ib] <= db;
         if (we_b & wbank) b1[ib] <= db;
      end
   end

   generate
      for (g = 0; g < 7; g = g + 1) begin : flat_gen
         assign flat0[g*16 +: 16] = b0[g];
         assign flat1[g*16 +: 16] = b1[g];
      end
   endgenerate

endmodule
`default_nettype wire

// file: flag_unit.v
// processor flag register with alu updates and acknowledge clears
// assumes write, alu update and acknowledges come from one sequencer
`timescale 1ns/100ps
`default_nettype none
`include "cpu_regs_defines.vh"

module flag_unit (
   // clock and reset
   input  wire        clk,
   input  wire        arst_n,
   // whole-register write
   input  wire        we,
   input  wire [15:0] wd,
   // alu results
   input  wire        alu_en,
   input  wire        alu_c,
   input  wire        alu_z,
   input  wire        alu_s,
   input  wire        alu_o,
   // acknowledges
   input  wire        hw_ack,
   input  wire        step_ack,
   input  wire        swi_exec,
   input  wire [5:0]  swi_num,
   // flag state
   output reg  [15:0] flags_r,
   output reg  [15:0] flags_nxt
);

   // ************************************************
   // next value: write, then alu, then clears
   // ************************************************
   always @* begin
      flags_nxt = flags_r;
      if (we)
         flags_nxt = wd & `FLG_WMASK;
      if (alu_en) begin
         flags_nxt[`FLG_C] = alu_c;
         flags_nxt[`FLG_Z] = alu_z;
         flags_nxt[`FLG_S] = alu_s;
         flags_nxt[`FLG_O] = alu_o;
      end
      if (step_ack)
         flags_nxt[`FLG_D] = 1'b0;
      if (hw_ack | step_ack) begin
         flags_nxt[`FLG_I] = 1'b0;
         flags_nxt[`FLG_U] = 1'b0;
      end
      if (swi_exec & (swi_num < `SWI_U_LIM))
         flags_nxt[`FLG_U] = 1'b0;
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         flags_r <= `FLG_RST;
      else
         flags_r <= flags_nxt;
   end

endmodule
`default_nettype wire

// file: cpu_regs_checker.sv
// concurrent checks on the processor register file ports
// bound into every cpu_regs instance; single clock domain
`timescale 1ns/100ps
`default_nettype none
module cpu_regs_checker (
   // clock and reset
   input wire logic        CLK,
   input wire logic        ARST_N,
   // control inputs
   input wire logic        ALU_EN, ALU_C, ALU_Z, ALU_S, ALU_O,
   input wire logic        INSN_DONE, PC_LOAD, IRQ_REQ, IRQ_ACK,
   input wire logic        SSTEP_ACK, SWI_EXEC,
   input wire logic [19:0] PC_VALUE,
   input wire logic [2:0]  IRQ_PRIO,
   input wire logic [5:0]  SWI_NUM,
   // watched outputs
   input wire logic        IRQ_TAKE, SSTEP_REQ, BANK,
   input wire logic [19:0] PROG_COUNTER,
   input wire logic [15:0] FLAGS
);
   // *****
   // properties
   // *****
   default clocking @(posedge CLK); endclocking
   default disable iff (!ARST_N);
   AST_IRQ_GATE: assert property (
      IRQ_TAKE == $past(IRQ_REQ && FLAGS[6] && IRQ_PRIO > FLAGS[14:12]))
      else $error("interrupt gate wrong");
   AST_ACK_CLR: assert property (IRQ_ACK |=> !FLAGS[6] && !FLAGS[7])
      else $error("ack left enable or stack flag");
   AST_STEP_CLR: assert property (SSTEP_ACK && !INSN_DONE |=> !FLAGS[1] && !SSTEP_REQ)
      else $error("step ack not cleared");
   AST_STEP_SET: assert property (INSN_DONE && FLAGS[1] |=> SSTEP_REQ)
      else $error("step request missing");
   AST_RSVD: assert property (FLAGS[11:8] == 4'h0 && !FLAGS[15])
      else $error("reserved flag bit set");
   AST_ALU: assert property (ALU_EN |=>
      {FLAGS[5], FLAGS[3:2], FLAGS[0]} == $past({ALU_O, ALU_S, ALU_Z, ALU_C}))
      else $error("alu flags not loaded");
   AST_BANK_TAKE: assert property (INSN_DONE |=> BANK == FLAGS[4])
      else $error("bank not taken");
   AST_BANK_HOLD: assert property (!INSN_DONE |=> $stable(BANK))
      else $error("bank changed mid instruction");
   AST_SWI_U: assert property (SWI_EXEC && SWI_NUM < 6'h20 |=> !FLAGS[7])
      else $error("software interrupt kept user stack");
   AST_PC_LOAD: assert property (PC_LOAD |=> PROG_COUNTER == $past(PC_VALUE))
      else $error("pc not loaded");
   cover property (IRQ_TAKE);
   cover property (INSN_DONE && FLAGS[1]);
   cover property (BANK && INSN_DONE);
endmodule
bind cpu_regs cpu_regs_checker chk (.*);
`default_nettype wire

// file: exec_model.sv
// model of the execution logic driving the operand port
// tasks called by the bench; signals change just after rising edges
`timescale 1ns/100ps
`default_nettype none
module exec_model (
   // clock
   input  wire logic        clk,
   // operand port
   input  wire logic [31:0] rd_data,
   output var  logic        wr_en,
   output var  logic [3:0]  wr_sel,
   output var  logic [1:0]  wr_size,
   output var  logic [31:0] wr_data,
   output var  logic [3:0]  rd_sel,
   output var  logic [1:0]  rd_size
);
   initial {wr_en, wr_sel, wr_size, wr_data, rd_sel, rd_size} = '0;
   task automatic wr(input logic [3:0] s, input logic [1:0] z, input logic [31:0] v);
      @(posedge clk);
      wr_en <= 1'b1;
      {wr_sel, wr_size, wr_data} <= {s, z, v};
      @(posedge clk);
      wr_en <= 1'b0;
      wr_data <= ~v;
   endtask
   task automatic rd(input logic [3:0] s, input logic [1:0] z, output logic [31:0] v);
      @(posedge clk);
      {rd_sel, rd_size} <= {s, z};
      @(posedge clk);
      @(negedge clk);
      v = rd_data;
   endtask
endmodule
`default_nettype wire

// file: test_cpu_regs.sv
// self-checking bench of the processor register file
// axi4-lite and control pins from here; operand port from exec_model
`timescale 1ns/100ps
`default_nettype none
`include "cpu_regs_defines.vh"
module test_cpu_regs;
   // *****
   // signals
   // *****
   logic        clk = 0, arst_n = 0, awvalid = 0, wvalid = 0, bready = 0;
   logic        arvalid = 0, rready = 0, alu_en = 0, alu_c = 0, alu_z = 0;
   logic        alu_s = 0, alu_o = 0, insn_done = 0, pc_load = 0, irq_req = 0;
   logic        irq_ack = 0, sstep_ack = 0, swi_exec = 0;
   logic [7:0]  awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, d;
   logic [19:0] pc_value = 0;
   logic [2:0]  irq_prio = 0;
   logic [5:0]  swi_num = 0;
   logic [1:0]  r;
   wire         awready, wready, bvalid, arready, rvalid, irq_take, sstep_req, bank, wr_en;
   wire  [1:0]  bresp, rresp, rd_size, wr_size;
   wire  [31:0] rdata, rd_data, wr_data;
   wire  [3:0]  rd_sel, wr_sel;
   wire  [15:0] ptr0, ptr1, fb, sb, sp, flags;
   wire  [19:0] pc, vb;
   int          fail_count = 0, num_checks = 0;
   cpu_regs dut (.CLK(clk), .ARST_N(arst_n), .AWADDR(awaddr), .AWVALID(awvalid),
      .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready),
      .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
      .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
      .RD_SEL(rd_sel), .RD_SIZE(rd_size), .RD_DATA(rd_data), .WR_EN(wr_en),
      .WR_SEL(wr_sel), .WR_SIZE(wr_size), .WR_DATA(wr_data), .ALU_EN(alu_en),
      .ALU_C(alu_c), .ALU_Z(alu_z), .ALU_S(alu_s), .ALU_O(alu_o), .INSN_DONE(insn_done),
      .PC_LOAD(pc_load), .PC_VALUE(pc_value), .IRQ_REQ(irq_req), .IRQ_PRIO(irq_prio),
      .IRQ_ACK(irq_ack), .SSTEP_ACK(sstep_ack), .SWI_EXEC(swi_exec), .SWI_NUM(swi_num),
      .IRQ_TAKE(irq_take), .SSTEP_REQ(sstep_req), .ADDR_PTR0(ptr0), .ADDR_PTR1(ptr1),
      .FRAME_BASE(fb), .STATIC_BASE(sb), .ACTIVE_SP(sp), .PROG_COUNTER(pc),
      .VEC_BASE(vb), .FLAGS(flags), .BANK(bank));
   exec_model pm (.clk(clk), .rd_data(rd_data), .wr_en(wr_en), .wr_sel(wr_sel),
      .wr_size(wr_size), .wr_data(wr_data), .rd_sel(rd_sel), .rd_size(rd_size));
   always #20 clk = ~clk;
   // *****
   // shared tasks
   // *****
   task automatic chk(input string n, input logic [35:0] s, input logic [35:0] e);
      num_checks++;
      if (s !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic aw(input logic [7:0] a, input logic [31:0] v);
      logic ta, tw, tb;
      @(posedge clk);
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'h7};
      forever begin
         @(negedge clk);
         {ta, tw, tb, r} = {awvalid & awready, wvalid & wready, bvalid, bresp};
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) begin
            bready <= 1'b0;
            break;
         end
      end
      @(negedge clk);
   endtask
   task automatic ar(input logic [7:0] a);
      logic ta, tb;
      @(posedge clk);
      {araddr, arvalid, rready} <= {a, 2'h3};
      forever begin
         @(negedge clk);
         {ta, tb, d, r} = {arvalid & arready, rvalid, rdata, rresp};
         @(posedge clk);
         if (ta) arvalid <= 1'b0;
         if (tb) begin
            rready <= 1'b0;
            break;
         end
      end
   endtask
   task automatic pulse(input int k);
      @(posedge clk);
      case (k)
         0: insn_done <= 1'b1;
         1: irq_ack <= 1'b1;
         2: sstep_ack <= 1'b1;
         3: alu_en <= 1'b1;
         4: swi_exec <= 1'b1;
         default: pc_load <= 1'b1;
      endcase
      @(posedge clk);
      {insn_done, irq_ack, sstep_ack, alu_en, swi_exec, pc_load} <= '0;
      @(negedge clk);
   endtask
   // *****
   // scenarios
   // *****
   task automatic t_reset;
      for (int i = 0; i < 20; i++) begin
         ar(8'(i * 4));
         chk("reset word", {d, r}, 34'h0);
      end
      ar(8'h50);
      chk("unmapped", {d, r}, {32'h0, `RESP_SLV});
   endtask
   task automatic t_views;
      pm.wr(`SEL_D0, `SZ_PAIR, 32'h89ab_cdef);
      pm.rd(`SEL_D2, `SZ_WORD, d);
      chk("pair upper", d, 32'h89ab);
      pm.wr(`SEL_D0, `SZ_BHI, 32'h12);
      pm.rd(`SEL_D0, `SZ_BLO, d);
      chk("low byte", d, 32'hef);
      pm.rd(`SEL_D0, `SZ_BHI, d);
      chk("high byte", d, 32'h12);
      pm.wr(`SEL_D1, `SZ_PAIR, 32'h1111_2222);
      pm.rd(`SEL_D3, `SZ_WORD, d);
      chk("second pair", d, 32'h1111);
      pm.wr(`SEL_A0, `SZ_PAIR, 32'haaaa_5555);
      pm.rd(`SEL_A0, `SZ_PAIR, d);
      chk("addr pair", d, 32'haaaa_5555);
      chk("pointers", {ptr1, ptr0}, 32'haaaa_5555);
      ar(8'h00);
      chk("data word", d, 32'h12ef);
   endtask
   task automatic t_bank;
      pm.wr(`SEL_FLG, `SZ_WORD, 32'h10);
      pm.wr(`SEL_D0, `SZ_WORD, 32'h7777);
      chk("bank early", bank, 1'b0);
      pulse(0);
      chk("bank taken", bank, 1'b1);
      pm.wr(`SEL_FB, `SZ_WORD, 32'h4242);
      pm.rd(`SEL_D0, `SZ_WORD, d);
      chk("second bank", d, 32'h0);
      chk("frame base", fb, 16'h4242);
      ar(8'h34);
      chk("second fb", d, 32'h4242);
      ar(8'h00);
      chk("first d0", d, 32'h7777);
      pm.wr(`SEL_FLG, `SZ_WORD, 32'h0);
      pulse(0);
   endtask
   task automatic t_flags;
      aw(8'h44, 32'hffff_ffff);
      chk("reserved", flags, 16'h70ff);
      @(posedge clk);
      {irq_req, irq_prio} <= 4'hf;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("level 7 blocks", irq_take, 1'b0);
      aw(8'h44, 32'h60c0);
      chk("higher accepted", irq_take, 1'b1);
      @(posedge clk);
      irq_prio <= 3'h6;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("equal refused", irq_take, 1'b0);
      pulse(1);
      chk("ack clears", flags[7:6], 2'h0);
      @(posedge clk);
      irq_req <= 1'b0;
   endtask
   task automatic t_step;
      aw(8'h44, 32'h2);
      pulse(0);
      chk("step request", sstep_req, 1'b1);
      pulse(2);
      chk("step cleared", {sstep_req, flags[1]}, 2'h0);
   endtask
   task automatic t_alu;
      for (int i = 0; i < 2; i++) begin
         @(posedge clk);
         {alu_o, alu_s, alu_z, alu_c} <= i ? 4'h5 : 4'ha;
         pulse(3);
         chk("alu flags", {flags[5], flags[3:2], flags[0]}, i ? 4'h5 : 4'ha);
      end
   endtask
   task automatic t_sp;
      aw(8'h3c, 32'h1234);
      aw(8'h40, 32'h5678);
      chk("irq stack", sp, 16'h5678);
      for (int i = 0; i < 2; i++) begin
         aw(8'h44, 32'h80);
         chk("user stack", sp, 16'h1234);
         @(posedge clk);
         swi_num <= i ? 6'h1f : 6'h20;
         pulse(4);
         chk("swi stack flag", flags[7], !i);
      end
   endtask
   task automatic t_misc;
      aw(8'h38, 32'hbeef);
      chk("static base", sb, 16'hbeef);
      chk("write ok", r, `RESP_OKAY);
      aw(8'h50, 32'h0);
      chk("bad write", r, `RESP_SLV);
      aw(8'h48, 32'h0fab_cde1);
      chk("vector base", vb, 20'hbcde1);
      @(posedge clk);
      pc_value <= 20'h54321;
      pulse(5);
      pm.rd(`SEL_PC, `SZ_WORD, d);
      chk("pc", pc, 20'h54321);
      chk("pc read", d, 32'h54321);
   endtask
   initial begin
      #2_000_000;
      fail_count++;
      stop_test;
   end
   initial begin
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      t_reset;
      t_views;
      t_bank;
      t_flags;
      t_step;
      t_alu;
      t_sp;
      t_misc;
      stop_test;
   end
endmodule
`default_nettype wire
